// [common/dcc_pkg.sv]
// Purpose: shared constants and types of the channel scheduler
// Assumes: 32-bit Avalon-MM slave with byte addresses
// Notes: a context entry is eight words, 256 entries
package dcc_pkg;
  localparam int DCC_DMA = 64;
  localparam int DCC_QK = 8;
  localparam int DCC_NQ = 4;
  localparam int DCC_QD = 16;
  localparam int DCC_ENTW = 8;
  localparam int DCC_CTXW = 2048;
  // Word positions inside a context entry
  localparam logic [2:0] DCC_W_OPT = 3'h0;
  localparam logic [2:0] DCC_W_SRC = 3'h1;
  localparam logic [2:0] DCC_W_CNT = 3'h2;
  localparam logic [2:0] DCC_W_DST = 3'h3;
  localparam logic [2:0] DCC_W_BIDX = 3'h4;
  localparam logic [2:0] DCC_W_LNK = 3'h5;
  localparam logic [2:0] DCC_W_CIDX = 3'h6;
  localparam logic [2:0] DCC_W_CCNT = 3'h7;
  // Options word fields, then the link value that ends a chain
  localparam int DCC_OPT_AB = 2;
  localparam int DCC_OPT_STATIC = 3;
  localparam int DCC_OPT_TCC = 12;
  localparam int DCC_OPT_TCINT = 20;
  localparam int DCC_OPT_CHEN = 22;
  localparam logic [15:0] DCC_LINK_END = 16'hffff;
  // Address pages (address bits 15:8)
  localparam logic [7:0] DCC_PG_REG = 8'h20;
  localparam logic [7:0] DCC_PG_DMAP = 8'h21;
  localparam logic [7:0] DCC_PG_QMAP = 8'h22;
  localparam logic [7:0] DCC_PG_QDBG = 8'h23;
  // Register offsets inside the register page, then queue threshold reset value and full count
  localparam logic [7:0] DCC_R_ER = 8'h00;
  localparam logic [7:0] DCC_R_ESR = 8'h08;
  localparam logic [7:0] DCC_R_ECR = 8'h10;
  localparam logic [7:0] DCC_R_EER = 8'h18;
  localparam logic [7:0] DCC_R_EESR = 8'h20;
  localparam logic [7:0] DCC_R_EECR = 8'h28;
  localparam logic [7:0] DCC_R_QER = 8'h30;
  localparam logic [7:0] DCC_R_QEESR = 8'h38;
  localparam logic [7:0] DCC_R_QEECR = 8'h40;
  localparam logic [7:0] DCC_R_IPR = 8'h48;
  localparam logic [7:0] DCC_R_ICR = 8'h50;
  localparam logic [7:0] DCC_R_IER = 8'h58;
  localparam logic [7:0] DCC_R_EMR = 8'h60;
  localparam logic [7:0] DCC_R_EMCR = 8'h68;
  localparam logic [7:0] DCC_R_QEMR = 8'h70;
  localparam logic [7:0] DCC_R_QEMCR = 8'h78;
  localparam logic [7:0] DCC_R_CCERR = 8'h80;
  localparam logic [7:0] DCC_R_CCECLR = 8'h88;
  localparam logic [7:0] DCC_R_QTHR = 8'h90;
  localparam logic [2:0] DCC_R_QSTAT = 3'h6;
  localparam logic [4:0] DCC_THR_RST = 5'h10;
  localparam logic [4:0] DCC_QFULL = 5'h10;
  typedef struct packed {
    logic quick;
    logic [5:0] chan;
    logic [7:0] entry;
  } dcc_qent_type;
  typedef struct packed {
    logic [31:0] options_word;
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] acnt;
    logic [15:0] bcnt;
    logic [15:0] ccnt;
    dcc_qent_type tag;
  } dcc_job_type;
  typedef struct packed {
    logic [1:0] queue;
    logic [7:0] entry;
  } dcc_dmap_type;
  typedef struct packed {
    logic [1:0] queue;
    logic [2:0] trig;
    logic [7:0] entry;
  } dcc_qmap_type;
  typedef enum {DCC_S_IDLE, DCC_S_LINK} dcc_st_type;
endpackage

// [core/dcc_sched.sv]
// What this block does
// - 256 context entries of eight 32-bit words
// - any channel maps to any context entry
// - source and destination indexes step independently
// - three dimensions, A or AB sync per trigger
// - writing mapped trigger word fires quick channel
// - static option bit freezes quick channel entries
// - separate completion and error interrupt outputs
// - four event queues, sixteen events deep each
// - queues hold only DMA and quick events
// - entry updated only when job is submitted
// - queue chosen by queue number registers
// - linking always active for all channels except static quick channel entries
// - link value ffff ends the chain
// - chain enable and completion enable are separate
// - set and clear registers for DMA event and enable bits except IER, which is written directly
// - queue contents, watermark and threshold visible
// - missed events recorded, error interrupt raised
// - triggering a null entry is an error
// - fixed priority, low channel first, DMA first
// - FIFO queues, queue zero served first
//
// Purpose: event scheduler with context memory and event queues
// Assumes: event pins asynchronous, engines on sys_clk
// Notes: at most one job leaves per cycle
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
module dcc_sched (
  input wire logic sys_clk, // 50 MHz clock
  input wire logic nrst, // async reset
  input wire logic [15:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic [63:0] dma_evt, // DMA event pins
  input wire logic [3:0] eng_rdy, // engine can take a job
  output logic job_vld, // job pulse
  output logic [1:0] job_eng, // engine of the job
  output dcc_pkg::dcc_job_type job_pkt, // job contents
  output logic irq_done, // completion interrupt
  output logic irq_err // error interrupt
);
  import dcc_pkg::*;

  logic [31:0] ctx_mem [DCC_CTXW];
  dcc_dmap_type dmap_q [DCC_DMA];
  dcc_qmap_type qmap_q [DCC_QK];
  logic [63:0] s1_q, s2_q, s3_q, lvl_q, evt_edge;
  logic [63:0] dma_pend_q, dma_en_q, ipr_q, ier_q, emr_q;
  logic [63:0] dma_set, dq_clr, done_set, chain_set, wm64;
  logic [7:0] qk_pend_q, qen_q, qemr_q, qk_trig, qk_clr;
  logic [4:0] ccerr_q;
  logic [3:0][4:0] qthr_q;
  logic ack_q, bus_we, ctx_sel, bus_ctx_wr, wr_reg;
  logic [7:0] pg, roff;
  logic [31:0] rd_val, rdata_q;
  logic arb_vld, arb_null, arb_take, enq;
  dcc_qent_type arb_ent;
  logic [1:0] arb_q;
  logic [3:0] q_full, q_empty, q_thx;
  dcc_qent_type q_head [DCC_NQ];
  dcc_qent_type q_dbg [DCC_NQ];
  logic [4:0] q_cnt [DCC_NQ];
  logic [4:0] q_wm [DCC_NQ];
  logic sub_vld, sub_go, stat, last, done, link_go;
  logic [1:0] sub_q;
  dcc_qent_type sub_ent;
  logic [31:0] sw [DCC_ENTW];
  logic [31:0] src_n, dst_n;
  logic [15:0] bcnt_n, ccnt_n;
  logic [5:0] tcc;
  dcc_st_type st_q;
  logic [2:0] lk_cnt_q;
  logic [7:0] lk_src_q, lk_dst_q;
  logic job_vld_q, irq_done_q, irq_err_q;
  logic [1:0] job_eng_q;
  dcc_job_type job_q;

  function automatic logic [31:0] hl(input logic [63:0] v);
    return avs_address[2] ? v[63:32] : v[31:0];
  endfunction

  function automatic logic ws(input logic [7:0] o);
    return wr_reg && roff == o;
  endfunction

  function automatic logic [31:0] sx(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  // Bus slave: one wait cycle, more for context writes during a link copy; write lands on the accepting edge
  assign pg = avs_address[15:8];
  assign roff = {avs_address[7:3], 3'h0};
  assign ctx_sel = avs_address[15:13] == 3'h0;
  assign bus_ctx_wr = avs_write && ctx_sel;
  assign bus_we = avs_write && ack_q;
  assign wr_reg = bus_we && pg == DCC_PG_REG;
  assign wm64 = avs_address[2] ? {avs_writedata, 32'h0}
                               : {32'h0, avs_writedata};
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata = rdata_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      // Context writes wait while a link copy owns the memory
      ack_q <= (avs_read || avs_write) && !ack_q &&
               !(bus_ctx_wr && st_q != DCC_S_IDLE);
      if (avs_read && !ack_q) begin
        rdata_q <= rd_val;
      end
    end
  end

  always_comb begin
    rd_val = 32'h0;
    if (ctx_sel) begin
      rd_val = ctx_mem[avs_address[12:2]];
    end else if (pg == DCC_PG_DMAP) begin
      rd_val = {22'h0, dmap_q[avs_address[7:2]]};
    end else if (pg == DCC_PG_QMAP) begin
      rd_val = {19'h0, qmap_q[avs_address[4:2]]};
    end else if (pg == DCC_PG_QDBG) begin
      rd_val = {17'h0, q_dbg[avs_address[7:6]]};
    end else if (pg == DCC_PG_REG) begin
      if (roff[7:5] == DCC_R_QSTAT) begin
        rd_val = {19'h0, q_wm[roff[4:3]], 3'h0, q_cnt[roff[4:3]]};
      end else begin
        case (roff)
          DCC_R_ER: rd_val = hl(dma_pend_q);
          DCC_R_EER: rd_val = hl(dma_en_q);
          DCC_R_QER: rd_val = {24'h0, qk_pend_q};
          DCC_R_QEESR: rd_val = {24'h0, qen_q};
          DCC_R_IPR: rd_val = hl(ipr_q);
          DCC_R_IER: rd_val = hl(ier_q);
          DCC_R_EMR: rd_val = hl(emr_q);
          DCC_R_QEMR: rd_val = {24'h0, qemr_q};
          DCC_R_CCERR: rd_val = {27'h0, ccerr_q};
          DCC_R_QTHR: rd_val = {12'h0, qthr_q};
          default: rd_val = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dmap_q <= '{default: '0};
      qmap_q <= '{default: '0};
    end else if (bus_we && pg == DCC_PG_DMAP) begin
      dmap_q[avs_address[7:2]] <= avs_writedata[9:0];
    end else if (bus_we && pg == DCC_PG_QMAP) begin
      qmap_q[avs_address[4:2]] <= avs_writedata[12:0];
    end
  end

  // Event pins: a rise counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 64'h0;
      s2_q <= 64'h0;
      s3_q <= 64'h0;
      lvl_q <= 64'h0;
    end else begin
      s1_q <= dma_evt;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Accepted level only moves when the last two stages agree
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
    end
  end
  assign evt_edge = s2_q & s3_q & ~lvl_q;

  genvar gq;
  generate
    for (gq = 0; gq < DCC_QK; gq++) begin : g_qtrig
      assign qk_trig[gq] = bus_we && ctx_sel && qen_q[gq] &&
        avs_address[12:5] == qmap_q[gq].entry &&
        avs_address[4:2] == qmap_q[gq].trig;
    end
  endgenerate

  // Pending, enable and missed bits; a set beats a clear
  assign dma_set = (evt_edge & dma_en_q) | (ws(DCC_R_ESR) ? wm64 : 64'h0)
                   | chain_set;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dma_pend_q <= 64'h0;
      dma_en_q <= 64'h0;
      emr_q <= 64'h0;
    end else begin
      dma_pend_q <= (dma_pend_q & ~dq_clr &
                     ~(ws(DCC_R_ECR) ? wm64 : 64'h0)) | dma_set;
      dma_en_q <= (dma_en_q & ~(ws(DCC_R_EECR) ? wm64 : 64'h0)) |
                  (ws(DCC_R_EESR) ? wm64 : 64'h0);
      emr_q <= (emr_q & ~(ws(DCC_R_EMCR) ? wm64 : 64'h0)) |
               (dma_set & dma_pend_q & ~dq_clr);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      qk_pend_q <= 8'h0;
      qen_q <= 8'h0;
      qemr_q <= 8'h0;
    end else begin
      qk_pend_q <= (qk_pend_q & ~qk_clr) | qk_trig;
      qen_q <= (qen_q & ~(ws(DCC_R_QEECR) ? wm64[7:0] : 8'h0)) |
               (ws(DCC_R_QEESR) ? wm64[7:0] : 8'h0);
      qemr_q <= (qemr_q & ~(ws(DCC_R_QEMCR) ? wm64[7:0] : 8'h0)) |
                (qk_trig & qk_pend_q & ~qk_clr);
    end
  end

  // Arbiter: later loop overrides, so DMA and low numbers win
  always_comb begin
    arb_vld = 1'b0;
    arb_ent = '0;
    arb_q = 2'h0;
    for (int i = DCC_QK - 1; i >= 0; i--) begin
      if (qk_pend_q[i]) begin
        arb_vld = 1'b1;
        arb_ent = {1'b1, 6'(i), qmap_q[i].entry};
        arb_q = qmap_q[i].queue;
      end
    end
    for (int i = DCC_DMA - 1; i >= 0; i--) begin
      if (dma_pend_q[i]) begin
        arb_vld = 1'b1;
        arb_ent = {1'b0, 6'(i), dmap_q[i].entry};
        arb_q = dmap_q[i].queue;
      end
    end
  end

  // An entry with every count zero is the null entry
  assign arb_null = ctx_mem[{arb_ent.entry, DCC_W_CNT}] == 32'h0 &&
                    ctx_mem[{arb_ent.entry, DCC_W_CCNT}][15:0] == 16'h0;
  assign arb_take = arb_vld && (arb_null || !q_full[arb_q]);
  assign enq = arb_vld && !arb_null && !q_full[arb_q];
  assign dq_clr = (arb_take && !arb_ent.quick) ?
                  (64'h1 << arb_ent.chan) : 64'h0;
  assign qk_clr = (arb_take && arb_ent.quick) ?
                  (8'h1 << arb_ent.chan[2:0]) : 8'h0;

  genvar g;
  generate
    for (g = 0; g < DCC_NQ; g++) begin : g_queue
      dcc_qent_type mem [DCC_QD];
      logic [3:0] wp_q, rp_q;
      logic [4:0] cnt_q, wm_q, cnt_d;
      logic push, pop;
      assign push = enq && arb_q == 2'(g);
      assign pop = sub_go && sub_q == 2'(g);
      assign cnt_d = cnt_q + {4'h0, push} - {4'h0, pop};
      always_ff @(posedge sys_clk) begin
        if (push) begin
          mem[wp_q] <= arb_ent;
        end
      end
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          wp_q <= 4'h0;
          rp_q <= 4'h0;
          cnt_q <= 5'h0;
          wm_q <= 5'h0;
        end else begin
          wp_q <= wp_q + {3'h0, push};
          rp_q <= rp_q + {3'h0, pop};
          cnt_q <= cnt_d;
          if (wr_reg && roff[7:5] == DCC_R_QSTAT && roff[4:3] == 2'(g)) begin
            wm_q <= cnt_d;
          end else if (cnt_d > wm_q) begin
            wm_q <= cnt_d;
          end
        end
      end
      assign q_full[g] = cnt_q == DCC_QFULL;
      assign q_empty[g] = cnt_q == 5'h0;
      assign q_thx[g] = cnt_q > qthr_q[g];
      assign q_head[g] = mem[rp_q];
      assign q_dbg[g] = mem[avs_address[5:2]];
      assign q_cnt[g] = cnt_q;
      assign q_wm[g] = wm_q;
      queue_bound_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        q_full[g] |-> ##1 cnt_q == DCC_QFULL || $past(pop))
        else $error("event queue took an event while full");
    end
  endgenerate

  // Submission: lowest queue whose engine is ready goes first
  always_comb begin
    sub_vld = 1'b0;
    sub_q = 2'h0;
    for (int i = DCC_NQ - 1; i >= 0; i--) begin
      if (!q_empty[i] && eng_rdy[i]) begin
        sub_vld = 1'b1;
        sub_q = 2'(i);
      end
    end
  end
  // Fabric-level priority is not resolved here, only engine readiness
  assign sub_go = sub_vld && st_q == DCC_S_IDLE && !bus_ctx_wr;
  assign sub_ent = q_head[sub_q];

  always_comb begin
    for (int k = 0; k < DCC_ENTW; k++) begin
      sw[k] = ctx_mem[{sub_ent.entry, 3'(k)}];
    end
  end

  // Next counts and addresses; A-sync steps one array per trigger
  always_comb begin
    stat = sub_ent.quick && sw[DCC_W_OPT][DCC_OPT_STATIC];
    bcnt_n = sw[DCC_W_CNT][31:16];
    ccnt_n = sw[DCC_W_CCNT][15:0] - 16'h1;
    src_n = sw[DCC_W_SRC] + sx(sw[DCC_W_CIDX][15:0]);
    dst_n = sw[DCC_W_DST] + sx(sw[DCC_W_CIDX][31:16]);
    last = sw[DCC_W_CCNT][15:0] == 16'h1;
    if (!sw[DCC_W_OPT][DCC_OPT_AB]) begin
      if (sw[DCC_W_CNT][31:16] == 16'h1) begin
        bcnt_n = sw[DCC_W_LNK][31:16];
      end else begin
        bcnt_n = sw[DCC_W_CNT][31:16] - 16'h1;
        ccnt_n = sw[DCC_W_CCNT][15:0];
        src_n = sw[DCC_W_SRC] + sx(sw[DCC_W_BIDX][15:0]);
        dst_n = sw[DCC_W_DST] + sx(sw[DCC_W_BIDX][31:16]);
        last = 1'b0;
      end
    end
  end

  assign tcc = sw[DCC_W_OPT][DCC_OPT_TCC +: 6];
  assign done = sub_go && (stat || last);
  assign done_set = (done && sw[DCC_W_OPT][DCC_OPT_TCINT]) ?
                    (64'h1 << tcc) : 64'h0;
  assign chain_set = (done && sw[DCC_W_OPT][DCC_OPT_CHEN]) ?
                     (64'h1 << tcc) : 64'h0;
  assign link_go = sub_go && last && !stat &&
                   sw[DCC_W_LNK][15:0] != DCC_LINK_END;

  // Context memory; the bus and the scheduler never write together
  always_ff @(posedge sys_clk) begin
    if (bus_we && ctx_sel) begin
      ctx_mem[avs_address[12:2]] <= avs_writedata;
    end else if (sub_go && !stat) begin
      ctx_mem[{sub_ent.entry, DCC_W_SRC}] <= src_n;
      ctx_mem[{sub_ent.entry, DCC_W_DST}] <= dst_n;
      ctx_mem[{sub_ent.entry, DCC_W_CNT}] <=
        {bcnt_n, sw[DCC_W_CNT][15:0]};
      ctx_mem[{sub_ent.entry, DCC_W_CCNT}] <=
        {sw[DCC_W_CCNT][31:16], ccnt_n};
    end else if (st_q == DCC_S_LINK) begin
      ctx_mem[{lk_dst_q, lk_cnt_q}] <= ctx_mem[{lk_src_q, lk_cnt_q}];
    end
  end

  // Link reload copies the follow-on entry, one word per cycle;
  // the arbiter may see a half copied entry meanwhile
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= DCC_S_IDLE;
      lk_cnt_q <= 3'h0;
      lk_src_q <= 8'h0;
      lk_dst_q <= 8'h0;
    end else begin
      case (st_q)
        DCC_S_IDLE: begin
          if (link_go) begin
            st_q <= DCC_S_LINK;
            lk_cnt_q <= 3'h0;
            lk_src_q <= sw[DCC_W_LNK][12:5];
            lk_dst_q <= sub_ent.entry;
          end
        end
        DCC_S_LINK: begin
          lk_cnt_q <= lk_cnt_q + 3'h1;
          if (lk_cnt_q == 3'h7) begin
            st_q <= DCC_S_IDLE;
          end
        end
        default: st_q <= DCC_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      job_vld_q <= 1'b0;
      job_eng_q <= 2'h0;
      job_q <= '0;
    end else begin
      job_vld_q <= sub_go;
      if (sub_go) begin
        job_eng_q <= sub_q;
        job_q <= {sw[DCC_W_OPT], sw[DCC_W_SRC], sw[DCC_W_DST],
                  sw[DCC_W_CNT][15:0], sw[DCC_W_CNT][31:16],
                  sw[DCC_W_CCNT][15:0], sub_ent};
      end
    end
  end
  assign job_vld = job_vld_q;
  assign job_eng = job_eng_q;
  assign job_pkt = job_q;

  // Status bits and the two interrupt lines
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ipr_q <= 64'h0;
      ier_q <= 64'h0;
      ccerr_q <= 5'h0;
      qthr_q <= {DCC_NQ{DCC_THR_RST}};
      irq_done_q <= 1'b0;
      irq_err_q <= 1'b0;
    end else begin
      ipr_q <= (ipr_q & ~(ws(DCC_R_ICR) ? wm64 : 64'h0)) | done_set;
      if (ws(DCC_R_IER)) begin
        ier_q <= avs_address[2] ? {avs_writedata, ier_q[31:0]}
                                : {ier_q[63:32], avs_writedata};
      end
      ccerr_q <= (ccerr_q & ~(ws(DCC_R_CCECLR) ? wm64[4:0] : 5'h0)) |
                 {arb_take && arb_null, q_thx};
      if (ws(DCC_R_QTHR) && !avs_address[2]) begin
        qthr_q <= avs_writedata[19:0];
      end
      irq_done_q <= |(ipr_q & ier_q);
      irq_err_q <= |emr_q || |qemr_q || |ccerr_q;
    end
  end
  assign irq_done = irq_done_q;
  assign irq_err = irq_err_q;

  sequence link_copy;
    (st_q == DCC_S_LINK) [*8] ##1 st_q == DCC_S_IDLE;
  endsequence

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  link_walk_a: assert property (link_go |=> link_copy)
    else $error("link reload did not copy eight words");
  link_end_a: assert property (sub_go && last && !stat &&
    sw[DCC_W_LNK][15:0] == DCC_LINK_END |=> st_q == DCC_S_IDLE)
    else $error("terminal link value started a reload");
  done_flag_a: assert property (done_set != 64'h0
    |=> ipr_q == ($past(ipr_q) | $past(done_set)) || $past(ws(DCC_R_ICR)))
    else $error("completion flag not set");
  chain_a: assert property (chain_set != 64'h0
    |=> (dma_pend_q & $past(chain_set)) == $past(chain_set))
    else $error("chained channel not made pending");
  miss_a: assert property (|(dma_set & dma_pend_q & ~dq_clr)
    |=> emr_q != 64'h0 ##1 irq_err)
    else $error("missed event not flagged");
  null_err_a: assert property (arb_take && arb_null
    |=> ccerr_q[4] ##1 irq_err)
    else $error("null entry trigger not reported");
  dma_first_a: assert property (arb_vld && dma_pend_q != 64'h0
    |-> !arb_ent.quick && dma_pend_q[arb_ent.chan] &&
        (dma_pend_q & ((64'h1 << arb_ent.chan) - 64'h1)) == 64'h0)
    else $error("quick channel beat a pending DMA event");
  submit_a: assert property (sub_go
    |-> (~q_empty & eng_rdy & ((4'h1 << sub_q) - 4'h1)) == 4'h0 ##1
        job_vld && job_eng == $past(sub_q) &&
        job_pkt.tag == $past(sub_ent))
    else $error("job not issued to selected engine");
  static_a: assert property (sub_go && stat |=> st_q == DCC_S_IDLE)
    else $error("static entry started a reload");
endmodule

// [tb/dcc_eng_model.sv]
// Purpose: stand-in for the four mover engines
// Assumes: a job follows one cycle after the edge that saw ready
// Notes: hold stalls all engines, else readiness wanders
module dcc_eng_model (
  input wire logic sys_clk, // clock
  input wire logic nrst, // reset, active low
  input wire logic hold, // stall every engine
  input wire logic job_vld, // job pulse
  input wire logic [1:0] job_eng, // engine of the job
  input wire dcc_pkg::dcc_job_type job_pkt, // job contents
  output logic [3:0] eng_rdy // engines ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import dcc_pkg::*;
  dcc_job_type jobs[$];
  logic [3:0] was_q;
  logic [3:0] pat_q;
  int bad = 0;
  // Fabric arbitration sits outside, so jobs are taken at once
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pat_q <= 4'h9;
      eng_rdy <= 4'h0;
      was_q <= 4'h0;
    end else begin
      pat_q <= {pat_q[2:0], pat_q[3] ^ pat_q[2]};
      eng_rdy <= hold ? 4'h0 : pat_q;
      was_q <= eng_rdy;
      if (job_vld === 1'b1) begin
        jobs.push_back(job_pkt);
        if (was_q[job_eng] !== 1'b1) bad++;
      end
    end
  end
endmodule

// [tb/dcc_sched_tb.sv]
// Purpose: self-checking bench of the channel scheduler
// Assumes: bus answers after one wait cycle or more
// Notes: context memory is written before every use
module dcc_sched_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dcc_pkg::*;
  logic sys_clk, nrst, avs_read, avs_write, avs_waitrequest, hold;
  logic [15:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, rsrc, rdst;
  logic [63:0] dma_evt;
  logic [3:0] eng_rdy;
  logic job_vld, irq_done, irq_err;
  logic [1:0] job_eng;
  dcc_job_type job_pkt;
  int err_total, tests_run, seed, i, e;
  dcc_sched dcc_sched_inst (.sys_clk(sys_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dma_evt(dma_evt), .eng_rdy(eng_rdy), .job_vld(job_vld),
    .job_eng(job_eng), .job_pkt(job_pkt), .irq_done(irq_done),
    .irq_err(irq_err));
  dcc_eng_model mdl_inst (.sys_clk(sys_clk), .nrst(nrst), .hold(hold),
    .job_vld(job_vld), .job_eng(job_eng), .job_pkt(job_pkt),
    .eng_rdy(eng_rdy));
  always #10 sys_clk = ~sys_clk;
  task close_out();
    $display("mismatches %0d of %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    if (avs_waitrequest !== 1'b0) err_total++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task wj(input int n);
    int k;
    k = 0;
    while (mdl_inst.jobs.size() < n && k < 900) begin
      @(posedge sys_clk);
      k++;
    end
    if (mdl_inst.jobs.size() < n) err_total++;
  endtask
  function automatic logic [15:0] cx(input int en, input int w);
    return 16'(en * 32 + w * 4);
  endfunction
  function automatic logic [31:0] step(input logic [31:0] v,
    input logic [15:0] x);
    return v + {{16{x[15]}}, x};
  endfunction
  function automatic logic [31:0] slot(input logic [5:0] c);
    return {18'h0, c, 8'h00};
  endfunction
  initial begin
    #1000000;
    err_total++;
    close_out();
  end
  initial begin
    seed = 19335;
    {sys_clk, nrst, avs_read, avs_write, avs_address} = '0;
    {avs_writedata, dma_evt, err_total, tests_run} = '0;
    hold = 1'b1;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    rsrc = $random(seed);
    rdst = $random(seed);
    bus(1, cx(3, 0), 32'h0);
    bus(1, cx(3, 1), rsrc);
    bus(1, cx(3, 2), 32'h0008_0004);
    bus(1, cx(3, 3), rdst);
    bus(1, cx(3, 4), 32'h0020_0010);
    bus(1, cx(3, 5), 32'hffff);
    bus(1, cx(3, 7), 32'h4);
    bus(1, 16'h2114, 32'h103);
    bus(1, 16'h2020, 32'h20);
    dma_evt <= 64'h20;
    repeat (8) @(posedge sys_clk);
    bus(0, cx(3, 1), 0);
    chk(rd, rsrc);
    chk(32'(mdl_inst.jobs.size()), 0);
    hold <= 1'b0;
    wj(1);
    chk(32'(mdl_inst.jobs[0].tag), {17'h0, 1'b0, 6'd5, 8'd3});
    chk({30'h0, job_eng}, 32'h1);
    bus(0, cx(3, 1), 0);
    chk(rd, step(rsrc, 16'h10));
    bus(0, cx(3, 3), 0);
    chk(rd, step(rdst, 16'h20));
    hold <= 1'b1;
    bus(1, cx(0, 0), 32'h0);
    bus(1, cx(0, 2), 32'h0064_0004);
    bus(1, cx(0, 5), 32'hffff);
    bus(1, cx(0, 7), 32'h64);
    bus(1, 16'h2090, 32'h84203);
    bus(1, 16'h2008, 32'hffffffff);
    bus(1, 16'h200c, 32'hffffffff);
    repeat (20) @(posedge sys_clk);
    bus(0, 16'h20c0, 0);
    chk(rd, {19'h0, DCC_QFULL, 3'h0, DCC_QFULL});
    bus(0, 16'h2300, 0);
    chk(rd, slot(6'd0));
    bus(0, 16'h2314, 0);
    chk(rd, slot(6'd6));
    bus(1, 16'h200c, 32'h8000_0000);
    bus(0, 16'h2064, 0);
    chk(rd, 32'h8000_0000);
    bus(0, 16'h2080, 0);
    chk(rd, 32'h1);
    chk({31'h0, irq_err}, 32'h1);
    bus(1, 16'h206c, 32'h8000_0000);
    bus(1, 16'h2090, 32'h84210);
    bus(1, 16'h2088, 32'h1f);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq_err}, 32'h0);
    hold <= 1'b0;
    wj(65);
    e = 0;
    for (i = 1; i < 65; i++) begin
      if (mdl_inst.jobs[i].tag.entry === 8'h0) begin
        if (e == 5) e++;
        chk(32'(mdl_inst.jobs[i].tag.chan), 32'(e));
        e++;
      end
    end
    rsrc = $random(seed);
    bus(1, cx(4, 0), 32'h0010_5000);
    bus(1, cx(4, 1), rsrc);
    bus(1, cx(4, 2), 32'h0001_0004);
    bus(1, cx(4, 5), 32'he0);
    bus(1, cx(7, 1), rdst);
    bus(1, cx(7, 5), 32'hffff);
    bus(1, cx(4, 7), 32'h1);
    bus(1, 16'h211c, 32'h204);
    bus(1, 16'h2058, 32'h20);
    bus(1, 16'h2008, 32'h80);
    wj(66);
    chk(mdl_inst.jobs[65].src, rsrc);
    chk({30'h0, job_eng}, 32'h2);
    repeat (20) @(posedge sys_clk);
    bus(0, 16'h2048, 0);
    chk(rd, 32'h20);
    chk({31'h0, irq_done}, 32'h1);
    bus(0, 16'h2000, 0);
    chk(rd, 32'h0);
    bus(0, cx(4, 1), 0);
    chk(rd, rdst);
    chk(32'(mdl_inst.jobs.size()), 66);
    bus(1, 16'h2050, 32'h20);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq_done}, 32'h0);
    bus(1, cx(5, 2), 32'h0);
    bus(1, cx(5, 7), 32'h0);
    bus(1, 16'h2120, 32'h5);
    bus(1, 16'h2008, 32'h100);
    repeat (10) @(posedge sys_clk);
    bus(0, 16'h2080, 0);
    chk(rd, 32'h10);
    chk({31'h0, irq_err}, 32'h1);
    chk(32'(mdl_inst.jobs.size()), 66);
    rsrc = $random(seed);
    bus(1, cx(8, 0), 32'h4);
    bus(1, cx(8, 1), rsrc);
    bus(1, cx(8, 2), 32'h0002_0004);
    bus(1, cx(8, 5), 32'hffff);
    bus(1, cx(8, 6), 32'h40);
    bus(1, cx(8, 7), 32'h5);
    bus(1, 16'h2124, 32'h8);
    bus(1, cx(6, 0), 32'h0040_900c);
    bus(1, cx(6, 1), rdst);
    bus(1, cx(6, 2), 32'h0002_0004);
    bus(1, cx(6, 5), 32'hffff);
    bus(1, 16'h220c, 32'h1f06);
    bus(1, 16'h2038, 32'h8);
    bus(1, cx(6, 7), 32'h3);
    wj(68);
    chk(32'(mdl_inst.jobs[66].tag), 32'h4306);
    chk(32'(mdl_inst.jobs[67].tag), 32'h0908);
    bus(0, cx(6, 1), 0);
    chk(rd, rdst);
    bus(0, cx(8, 1), 0);
    chk(rd, step(rsrc, 16'h40));
    bus(0, cx(8, 7), 0);
    chk(rd, 32'h4);
    bus(0, 16'h2400, 0);
    chk(rd, 32'h0);
    chk(32'(mdl_inst.bad), 0);
    close_out();
  end
endmodule
